/* File: bus_cpu_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbus_consts.svh"
module bus_cpu_end
  import pbus_pkg::*;
(
  // Clock, enable and reset
  input  wire logic                   core_clk,
  input  wire logic                   clk_en,
  input  wire logic                   rst_n,
  // Request queue from the core
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire bus_req_t               req_word,
  // Read data to the core
  output logic                        rd_valid,
  output logic [`BUS_DATA_W-1:0]      rd_data,
  // Bus link
  pbus_if.cpu                         bus
);

  // ****************************************
  // Request queue
  // ****************************************
  logic     fifo_valid;
  logic     pop;
  bus_req_t fifo_word;

  req_fifo #(
    .WIDTH (`BUS_REQ_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .clk_en    (clk_en),
    .rst_n     (rst_n),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req_word),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_word)
  );

  // ****************************************
  // Bus state machine
  // ****************************************
  bus_state_t             state_q, state_d;
  logic                   phase_q, phase_d;
  bus_req_t               cur_q, cur_d;
  bus_req_t               pin_q, pin_d;
  logic                   na_q, na_d;
  logic                   ads_n_q, ads_n_d;
  logic [`BUS_DATA_W-1:0] dout_q, dout_d;
  logic                   doe_q, doe_d;
  logic                   whold_q, whold_d;
  logic                   rdv_q, rdv_d;
  logic [`BUS_DATA_W-1:0] rdd_q, rdd_d;
  logic                   hack_q, hack_d;
  logic                   ready;
  logic                   done;
  logic                   issue;
  logic                   go_plain;
  logic                   take;

  // Next state, pins and data path
  always_comb
  begin
    state_d  = state_q;
    phase_d  = phase_q;
    cur_d    = cur_q;
    pin_d    = pin_q;
    na_d     = na_q;
    ads_n_d  = ads_n_q;
    dout_d   = dout_q;
    doe_d    = doe_q;
    whold_d  = whold_q;
    rdv_d    = 1'b0;
    rdd_d    = rdd_q;
    hack_d   = hack_q;
    issue    = 1'b0;
    go_plain = 1'b0;
    take     = 1'b0;
    ready    = !bus.cycle_done_n;
    done     = 1'b0;
    if (phase_q == `PH1)
    begin
      // End of phase one
      phase_d = `PH2;
      na_d    = !bus.next_address_request_n;
      whold_d = 1'b0;
      if ((state_q == first_state || state_q == pipelined_first_state) && cur_q.write)
      begin
        doe_d  = 1'b1;
        dout_d = cur_q.wdata;
      end
      else if (whold_q)
      begin
        doe_d = 1'b0;
      end
    end
    else
    begin
      // End of the bus state
      phase_d = `PH1;
      ads_n_d = 1'b1;
      done    = ready && (state_q == plain_second_state ||
                          state_q == pipelined_second_state ||
                          state_q == idle_second_state);
      if (done && cur_q.write)
      begin
        whold_d = 1'b1;
      end
      else if (done)
      begin
        rdv_d = 1'b1;
        rdd_d = bus.data_bus;
      end
      unique case (state_q)
        idle_state, hold_state:
        begin
          go_plain = 1'b1;
        end
        first_state:
        begin
          state_d = plain_second_state;
        end
        plain_second_state:
        begin
          if (ready)
            go_plain = 1'b1;
          else if (na_q && fifo_valid)
            issue = 1'b1;
        end
        pipelined_first_state:
        begin
          if (na_q && fifo_valid)
            issue = 1'b1;
          else if (fifo_valid)
            state_d = plain_second_state;
          else
            state_d = idle_second_state;
        end
        pipelined_second_state:
        begin
          if (ready)
          begin
            state_d = pipelined_first_state;
            cur_d   = pin_q;
          end
          else
          begin
            ads_n_d = 1'b0;
          end
        end
        idle_second_state:
        begin
          if (ready)
            go_plain = 1'b1;
          else if (fifo_valid)
            issue = 1'b1;
        end
        default:
        begin
          state_d = idle_state;
        end
      endcase
      if (issue)
      begin
        state_d = pipelined_second_state;
        pin_d   = fifo_word;
        ads_n_d = 1'b0;
        take    = 1'b1;
      end
      if (go_plain)
      begin
        if (bus.hold)
        begin
          state_d = hold_state;
          hack_d  = 1'b1;
        end
        else if (fifo_valid)
        begin
          state_d = first_state;
          hack_d  = 1'b0;
          cur_d   = fifo_word;
          pin_d   = fifo_word;
          ads_n_d = 1'b0;
          take    = 1'b1;
        end
        else
        begin
          state_d = idle_state;
          hack_d  = 1'b0;
        end
      end
    end
  end

  assign pop = take && clk_en;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= idle_state;
      phase_q <= `PH1;
      cur_q   <= '0;
      pin_q   <= '0;
      na_q    <= 1'b0;
      ads_n_q <= 1'b1;
      dout_q  <= '0;
      doe_q   <= 1'b0;
      whold_q <= 1'b0;
      rdv_q   <= 1'b0;
      rdd_q   <= '0;
      hack_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      cur_q   <= cur_d;
      pin_q   <= pin_d;
      na_q    <= na_d;
      ads_n_q <= ads_n_d;
      dout_q  <= dout_d;
      doe_q   <= doe_d;
      whold_q <= whold_d;
      rdv_q   <= rdv_d;
      rdd_q   <= rdd_d;
      hack_q  <= hack_d;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  assign bus.address_strobe_n    = ads_n_q;
  assign bus.word_address        = pin_q.addr;
  assign bus.upper_byte_enable_n = !pin_q.upper_en;
  assign bus.lower_byte_enable_n = !pin_q.lower_en;
  assign bus.memory_or_io        = pin_q.mem_io;
  assign bus.write_or_read       = pin_q.write;
  assign bus.data_or_control     = pin_q.data_ctrl;
  assign bus.lock_n              = !pin_q.lock;
  assign bus.hold_ack            = hack_q;
  assign bus.cpu_dout            = dout_q;
  assign bus.cpu_doe             = doe_q;
  assign rd_valid                = rdv_q;
  assign rd_data                 = rdd_q;
endmodule : bus_cpu_end
`default_nettype wire

/* File: bus_sys_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbus_consts.svh"
module bus_sys_end
  import pbus_pkg::*;
(
  // Clock, enable and reset
  input  wire logic                   core_clk,
  input  wire logic                   clk_en,
  input  wire logic                   rst_n,
  // Responder setup
  input  wire logic [`WAIT_W-1:0]     wait_states,
  input  wire logic                   pipe_en,
  input  wire logic                   hold_req,
  input  wire logic [`BUS_DATA_W-1:0] rd_word,
  // Captured writes and hold grant
  output logic                        wr_valid,
  output logic [`BUS_ADDR_W-1:0]      wr_addr,
  output logic [`BUS_DATA_W-1:0]      wr_data,
  output logic                        hold_granted,
  // Bus link
  pbus_if.sys                         bus
);

  // ****************************************
  // Responder state
  // ****************************************
  logic                   phase_q, phase_d;
  logic                   act_q, act_d;
  logic                   pipe_q, pipe_d;
  logic [`WAIT_W:0]       st_q, st_d;
  logic                   cwr_q, cwr_d;
  logic [`BUS_ADDR_W-1:0] cad_q, cad_d;
  logic                   npend_q, npend_d;
  logic                   nwr_q, nwr_d;
  logic [`BUS_ADDR_W-1:0] nad_q, nad_d;
  logic                   rdy_n_q, rdy_n_d;
  logic                   na_n_q, na_n_d;
  logic                   doe_q, doe_d;
  logic [`BUS_DATA_W-1:0] dout_q, dout_d;
  logic                   wrv_q, wrv_d;
  logic [`BUS_ADDR_W-1:0] wra_q, wra_d;
  logic [`BUS_DATA_W-1:0] wrd_q, wrd_d;
  logic                   hold_q, hold_d;
  logic                   hgr_q, hgr_d;
  logic                   strobe;
  logic                   ack;
  logic [`WAIT_W:0]       need;

  // Track cycles, answer with done and next-address request
  always_comb
  begin
    phase_d = phase_q;
    act_d   = act_q;
    pipe_d  = pipe_q;
    st_d    = st_q;
    cwr_d   = cwr_q;
    cad_d   = cad_q;
    npend_d = npend_q;
    nwr_d   = nwr_q;
    nad_d   = nad_q;
    rdy_n_d = rdy_n_q;
    na_n_d  = na_n_q;
    doe_d   = doe_q;
    dout_d  = dout_q;
    wrv_d   = 1'b0;
    wra_d   = wra_q;
    wrd_d   = wrd_q;
    hold_d  = hold_req;
    hgr_d   = bus.hold_ack;
    strobe  = !bus.address_strobe_n;
    ack     = act_q && !rdy_n_q;
    need    = {1'b0, wait_states} + 1'b1;
    if (phase_q == `PH1)
    begin
      phase_d = `PH2;
      rdy_n_d = !(act_q && st_q >= need);
      doe_d   = act_q && !cwr_q && (st_q != '0);
      dout_d  = rd_word;
    end
    else
    begin
      phase_d = `PH1;
      if (ack)
      begin
        rdy_n_d = 1'b1;
        wrv_d   = cwr_q;
        wra_d   = cad_q;
        wrd_d   = bus.data_bus;
      end
      if (ack || !act_q)
      begin
        if (act_q && (npend_q || strobe))
        begin
          pipe_d  = 1'b1;
          st_d    = '0;
          cwr_d   = npend_q ? nwr_q : bus.write_or_read;
          cad_d   = npend_q ? nad_q : bus.word_address;
          npend_d = 1'b0;
        end
        else if (strobe)
        begin
          act_d  = 1'b1;
          pipe_d = 1'b0;
          st_d   = {{`WAIT_W{1'b0}}, 1'b1};
          cwr_d  = bus.write_or_read;
          cad_d  = bus.word_address;
        end
        else
        begin
          act_d = 1'b0;
        end
      end
      else
      begin
        if (st_q != '1)
          st_d = st_q + 1'b1;
        if (strobe && !npend_q)
        begin
          npend_d = 1'b1;
          nwr_d   = bus.write_or_read;
          nad_d   = bus.word_address;
        end
      end
      na_n_d = !(pipe_en && act_d && (pipe_d || wait_states != '0));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= `PH1;
      act_q   <= 1'b0;
      pipe_q  <= 1'b0;
      st_q    <= '0;
      cwr_q   <= 1'b0;
      cad_q   <= '0;
      npend_q <= 1'b0;
      nwr_q   <= 1'b0;
      nad_q   <= '0;
      rdy_n_q <= 1'b1;
      na_n_q  <= 1'b1;
      doe_q   <= 1'b0;
      dout_q  <= '0;
      wrv_q   <= 1'b0;
      wra_q   <= '0;
      wrd_q   <= '0;
      hold_q  <= 1'b0;
      hgr_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_q <= phase_d;
      act_q   <= act_d;
      pipe_q  <= pipe_d;
      st_q    <= st_d;
      cwr_q   <= cwr_d;
      cad_q   <= cad_d;
      npend_q <= npend_d;
      nwr_q   <= nwr_d;
      nad_q   <= nad_d;
      rdy_n_q <= rdy_n_d;
      na_n_q  <= na_n_d;
      doe_q   <= doe_d;
      dout_q  <= dout_d;
      wrv_q   <= wrv_d;
      wra_q   <= wra_d;
      wrd_q   <= wrd_d;
      hold_q  <= hold_d;
      hgr_q   <= hgr_d;
    end
  end

  // Pin and user drive
  assign bus.next_address_request_n = na_n_q;
  assign bus.cycle_done_n           = rdy_n_q;
  assign bus.hold                   = hold_q;
  assign bus.sys_dout               = dout_q;
  assign bus.sys_doe                = doe_q;
  assign wr_valid                   = wrv_q;
  assign wr_addr                    = wra_q;
  assign wr_data                    = wrd_q;
  assign hold_granted               = hgr_q;
endmodule : bus_sys_end
`default_nettype wire

/* File: pbus_consts.svh */
// Contract
// - System picks pipelining per cycle via next_address_request
// - Plain cycle: sample request phase 2, act in waits
// - Early address driven with address_strobe before cycle ends
// - Pipelined first state: request plus pending goes pipelined
// - Nothing pending: idle_second_state, no new address
// - Cycle ends only in second states on cycle_done
// - Read: bus released, data captured on cycle_done
// - Write: drive from phase two, hold one phase
// - No cycle_done: repeat second state as wait
// - Repeated pipelined_second_state keeps strobe and address
// - No request early: plain second, then pipelined later
// - Late request in idle_second_state adds pipelined wait
// - One entry to pipelined_second_state keeps pipelining
// - System starts pipelining only in waited plain cycle
// - First cycle after reset, idle, hold non-pipelined
// - Request sampled each phase one end until done
// - Transition cycle then two-state pipelined cycles
// - Pipelining continues only if cycle ends pipelined
// - Pipelined cycle starts in pipelined_first_state after issue
// - Bus state is two double_rate_clock periods
// - Cycle type on four outputs; the code drives all four: memory_or_io, write_or_read, data_or_control, lock_n
// - After plain end: idle or hold state; the code goes straight to first_state when a request is queued
`ifndef PBUS_CONSTS_SVH
`define PBUS_CONSTS_SVH

`define BUS_DATA_W 16
`define BUS_ADDR_W 23
`define BUS_REQ_W  45
`define FIFO_DEPTH 16
`define WAIT_W     4
`define PH1        1'b0
`define PH2        1'b1

`endif

/* File: pbus_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbus_consts.svh"
interface pbus_if;
  logic                   address_strobe_n;
  logic [`BUS_ADDR_W-1:0] word_address;
  logic                   upper_byte_enable_n;
  logic                   lower_byte_enable_n;
  logic                   memory_or_io;
  logic                   write_or_read;
  logic                   data_or_control;
  logic                   lock_n;
  logic                   next_address_request_n;
  logic                   cycle_done_n;
  logic                   hold;
  logic                   hold_ack;
  logic [`BUS_DATA_W-1:0] cpu_dout;
  logic                   cpu_doe;
  logic [`BUS_DATA_W-1:0] sys_dout;
  logic                   sys_doe;
  logic [`BUS_DATA_W-1:0] data_bus;

  // Resolved data bus level
  assign data_bus = cpu_doe ? cpu_dout : (sys_doe ? sys_dout : '0);

  modport cpu (
    output address_strobe_n, word_address, upper_byte_enable_n,
    output lower_byte_enable_n, memory_or_io, write_or_read,
    output data_or_control, lock_n, hold_ack, cpu_dout, cpu_doe,
    input  next_address_request_n, cycle_done_n, hold, data_bus
  );

  modport sys (
    input  address_strobe_n, word_address, upper_byte_enable_n,
    input  lower_byte_enable_n, memory_or_io, write_or_read,
    input  data_or_control, lock_n, hold_ack, data_bus,
    output next_address_request_n, cycle_done_n, hold, sys_dout, sys_doe
  );
endinterface : pbus_if
`default_nettype wire

/* File: pbus_pkg.sv */
`default_nettype none
package pbus_pkg;
`include "pbus_consts.svh"

  // ****************************************
  // Bus states
  // ****************************************
  typedef enum logic [2:0] {
    idle_state             = 3'b000,
    first_state            = 3'b001,
    plain_second_state     = 3'b010,
    pipelined_first_state  = 3'b011,
    pipelined_second_state = 3'b100,
    idle_second_state      = 3'b101,
    hold_state             = 3'b110
  } bus_state_t;

  // ****************************************
  // Queued bus request
  // ****************************************
  typedef struct packed {
    logic                    write;
    logic                    mem_io;
    logic                    data_ctrl;
    logic                    lock;
    logic                    upper_en;
    logic                    lower_en;
    logic [`BUS_ADDR_W-1:0]  addr;
    logic [`BUS_DATA_W-1:0]  wdata;
  } bus_req_t;

endpackage : pbus_pkg
`default_nettype wire

/* File: pbus_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbus_consts.svh"
module pbus_props (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  // Bus link
  input wire logic                   address_strobe_n,
  input wire logic [`BUS_ADDR_W-1:0] word_address,
  input wire logic                   write_or_read,
  input wire logic                   memory_or_io,
  input wire logic                   data_or_control,
  input wire logic                   cycle_done_n,
  input wire logic                   cpu_doe,
  input wire logic                   sys_doe,
  input wire logic                   hold_ack
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Cycle definition bundle
  wire logic [`BUS_ADDR_W+2:0] cdef = {word_address, write_or_read, memory_or_io, data_or_control};

  chk_rst_idle: assert property (!$past(rst_n) |-> address_strobe_n && !cpu_doe)
    else $error("bus active right after reset");
  chk_strobe_state: assert property ($fell(address_strobe_n) |=> !address_strobe_n)
    else $error("strobe shorter than one bus state");
  chk_def_stable: assert property (!address_strobe_n && $past(!address_strobe_n) |-> $stable(cdef))
    else $error("address moved while strobe held");
  chk_done_pulse: assert property ($fell(cycle_done_n) |=> cycle_done_n)
    else $error("cycle done held past its edge");
  chk_write_hold: assert property (!cycle_done_n && cpu_doe |=> cpu_doe)
    else $error("write data dropped at the ack");
  chk_doe_write: assert property ($rose(cpu_doe) |-> write_or_read)
    else $error("data driven on a read");
  chk_read_drive: assert property (!cycle_done_n && !cpu_doe |-> sys_doe)
    else $error("read acked with bus undriven");
  chk_hold_quiet: assert property (hold_ack |-> address_strobe_n)
    else $error("strobe driven in hold");
  chk_hold_float: assert property (hold_ack && $past(hold_ack) |-> !cpu_doe)
    else $error("data bus driven in hold after write hold time");
  chk_done_bound: assert property ($fell(address_strobe_n) |-> ##[1:80] !cycle_done_n)
    else $error("cycle never acked");
  chk_ack_ends_strobe: assert property (!cycle_done_n && !address_strobe_n |=> address_strobe_n)
    else $error("strobe held into pipelined first state");

  // Main scenarios
  cov_pipe_ack: cover property (!cycle_done_n && !address_strobe_n);
  cov_hold: cover property ($rose(hold_ack));
  cov_wr_ack: cover property (!cycle_done_n && cpu_doe);
endmodule : pbus_props
`default_nettype wire

/* File: pipelined_address_bus_fsm_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbus_consts.svh"
module pipelined_address_bus_fsm_tb_top
  import pbus_pkg::*;
;
  logic                   core_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   clk_en = 1'b1;
  logic                   req_valid = 1'b0;
  logic                   req_ready;
  bus_req_t               req_word = '0;
  logic                   rd_valid;
  logic [`BUS_DATA_W-1:0] rd_data;
  logic [`WAIT_W-1:0]     wait_states = '0;
  logic                   pipe_en = 1'b0;
  logic                   hold_req = 1'b0;
  logic [`BUS_DATA_W-1:0] rd_word = '0;
  logic                   wr_valid;
  logic [`BUS_ADDR_W-1:0] wr_addr;
  logic [`BUS_DATA_W-1:0] wr_data;
  logic                   hold_granted;
  logic                   prev_ads = 1'b1;
  logic [31:0]            seed = 32'h0000cb22;
  int                     failures = 0;
  int                     n_tests = 0;
  int                     pip_cnt = 0;
  bus_req_t               expq[$];
  bus_req_t               pinq[$];

  pbus_if pbus ();

  bus_cpu_end i_bus_cpu_end (
    .core_clk (core_clk),
    .clk_en   (clk_en),
    .rst_n    (rst_n),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_word (req_word),
    .rd_valid (rd_valid),
    .rd_data  (rd_data),
    .bus      (pbus)
  );

  bus_sys_end i_bus_sys_end (
    .core_clk    (core_clk),
    .clk_en      (clk_en),
    .rst_n       (rst_n),
    .wait_states (wait_states),
    .pipe_en     (pipe_en),
    .hold_req    (hold_req),
    .rd_word     (rd_word),
    .wr_valid    (wr_valid),
    .wr_addr     (wr_addr),
    .wr_data     (wr_data),
    .hold_granted(hold_granted),
    .bus         (pbus)
  );

  pbus_props i_pbus_props (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .address_strobe_n(pbus.address_strobe_n),
    .word_address    (pbus.word_address),
    .write_or_read   (pbus.write_or_read),
    .memory_or_io    (pbus.memory_or_io),
    .data_or_control (pbus.data_or_control),
    .cycle_done_n    (pbus.cycle_done_n),
    .cpu_doe         (pbus.cpu_doe),
    .sys_doe         (pbus.sys_doe),
    .hold_ack        (pbus.hold_ack)
  );

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected pin image, enables and lock active low
  function automatic logic [63:0] pins_of(bus_req_t r);
    return 64'({r.addr, ~r.upper_en, ~r.lower_en, r.mem_io, r.write, r.data_ctrl, ~r.lock});
  endfunction : pins_of

  // Acks that end with the next address out
  function automatic int exp_pip(int n);
    return (pipe_en && wait_states != '0) ? n - 1 : 0;
  endfunction : exp_pip

  task automatic cmp_val(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_cnt(string what, int exp, int got);
    n_tests++;
    if (got != exp)
    begin
      failures++;
      $display("[ERR] %s exp %0d got %0d", what, exp, got);
    end
  endtask : cmp_cnt

  task automatic print_verdict();
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Push n random requests back to back
  task automatic burst(int n);
    bus_req_t r;
    logic     ok;
    pip_cnt = 0;
    rd_word = 16'(rnd());
    for (int i = 0; i < n; i++)
    begin
      r = 45'({rnd(), rnd()});
      req_valid = 1'b1;
      req_word = r;
      ok = req_ready;
      @(negedge core_clk);
      if (ok)
      begin
        expq.push_back(r);
        pinq.push_back(r);
      end
    end
    req_valid = 1'b0;
  endtask : burst

  // Wait until every queued request has completed
  task automatic drain();
    for (int i = 0; i < 4000 && expq.size() > 0; i++)
      @(negedge core_clk);
    if (expq.size() > 0)
    begin
      cmp_cnt("drain", 0, expq.size());
      print_verdict();
    end
    repeat (4) @(negedge core_clk);
  endtask : drain

  // Clock
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  // Pin, pipelining and result monitor
  always @(negedge core_clk)
  begin
    bus_req_t e;
    if (!pbus.address_strobe_n && prev_ads)
    begin
      if (pinq.size() == 0)
        cmp_cnt("spare cycle", 0, 1);
      else
        cmp_val("pins", pins_of(pinq.pop_front()), 64'({pbus.word_address,
          pbus.upper_byte_enable_n, pbus.lower_byte_enable_n, pbus.memory_or_io,
          pbus.write_or_read, pbus.data_or_control, pbus.lock_n}));
    end
    prev_ads = pbus.address_strobe_n;
    if (!pbus.cycle_done_n && !pbus.address_strobe_n)
      pip_cnt++;
    if (wr_valid || rd_valid)
    begin
      if (expq.size() == 0)
        cmp_cnt("spare result", 0, 1);
      else
      begin
        e = expq.pop_front();
        cmp_val("write flag", 64'(e.write), 64'(wr_valid));
        if (wr_valid)
          cmp_val("write word", 64'({e.addr, e.wdata}), 64'({wr_addr, wr_data}));
        else
          cmp_val("read data", 64'(rd_word), 64'(rd_data));
      end
    end
  end

  // Main sequence
  initial
  begin
    int n;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    // Both modes over zero, one, most and random waits
    for (int k = 0; k < 8; k++)
    begin
      pipe_en = k[0];
      wait_states = (k < 2) ? 4'h0 : (k < 4) ? 4'h1 : (k < 6) ? 4'hf : 4'(rnd() % 14 + 2);
      n = 2 + int'(rnd() % 5);
      burst(n);
      drain();
      cmp_cnt("pipelined acks", exp_pip(n), pip_cnt);
    end
    // Stall in hold, fill the queue until refused, then drain
    hold_req = 1'b1;
    for (int i = 0; i < 40 && hold_granted !== 1'b1; i++)
      @(negedge core_clk);
    cmp_val("hold granted", 64'h1, 64'(hold_granted));
    burst(20);
    cmp_cnt("queue depth", `FIFO_DEPTH, expq.size());
    cmp_val("refused", 64'h0, 64'(req_ready));
    hold_req = 1'b0;
    drain();
    cmp_cnt("pipelined acks", exp_pip(`FIFO_DEPTH), pip_cnt);
    // Reset during the waits of a cycle
    pipe_en = 1'b0;
    wait_states = 4'hf;
    burst(4);
    repeat (5) @(negedge core_clk);
    rst_n = 1'b0;
    expq.delete();
    pinq.delete();
    @(negedge core_clk);
    cmp_val("strobe", 64'h1, 64'(pbus.address_strobe_n));
    cmp_val("data enable", 64'h0, 64'(pbus.cpu_doe));
    rst_n = 1'b1;
    pipe_en = 1'b1;
    burst(3);
    drain();
    cmp_cnt("pipelined acks", exp_pip(3), pip_cnt);
    print_verdict();
  end
endmodule : pipelined_address_bus_fsm_tb_top
`default_nettype wire

/* File: req_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbus_consts.svh"
module req_fifo #(
  parameter int unsigned WIDTH = `BUS_REQ_W,
  parameter int unsigned DEPTH = `FIFO_DEPTH
) (
  // Clock, enable and reset
  input  wire logic             core_clk,
  input  wire logic             clk_en,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PTR_W:0]   cnt_q, cnt_d;
  logic             ready_q, ready_d;
  logic             push, pop;

  // Pointer and count update
  always_comb
  begin
    push  = in_valid && ready_q;
    pop   = out_ready && (cnt_q != '0);
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
    ready_d = (cnt_d != FULL_CNT);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      ready_q <= 1'b1;
    end
    else if (clk_en)
    begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      ready_q <= ready_d;
    end
  end

  // Storage entries
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        mem_q[i] <= '0;
      else if (clk_en && push && (wr_q == PTR_W'(i)))
        mem_q[i] <= in_data;
    end
  end

  assign in_ready  = ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
endmodule : req_fifo
`default_nettype wire
